// [serial_command_error_checker.sv]
// checks dedicated-protocol command frames and reports a set core fault, else the first frame error
// assumes rx bytes and line faults arrive on ref_clk; coreLinkOk is async
`timescale 1ns/1ps
`default_nettype none
`include "serial_command_error_checker_defs.svh"
module serial_command_error_checker (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxOverrun,
  input  wire logic        rxFrameErr,
  input  wire logic        coreLinkOk,
  output var  logic        errValid,
  output var  logic [15:0] errCode,
  output var  logic        frameOk,
  output var  logic        coreFault
);
  serial_command_error_checker_pkg::state_e state;
  serial_command_error_checker_pkg::state_e next_state;
  serial_command_error_checker_pkg::err_t   firstErr;
  serial_command_error_checker_pkg::err_t   hitCode;
  logic        hit;
  logic        hasErr;
  logic [3:0]  pos;
  logic [8:0]  byteCnt;
  logic [7:0]  cmdLow;
  logic        isBlock;
  logic        byteType;
  logic [15:0] addr;
  logic [7:0]  cnt;
  logic [7:0]  bccSum;
  logic [3:0]  bccHi;
  logic        endFrame;
  logic        isRw;
  logic        isMon;
  logic        linkMeta;
  logic        linkSync;
  logic        linkPrev;

  char_class_if cc ();
  assign cc.ch = rxData;
  ascii_char_class u_cls (
    .cc (cc)
  );

  assign isRw  = cmdLow == 8'h72 || cmdLow == 8'h77;
  assign isMon = cmdLow == 8'h78 || cmdLow == 8'h79;
  assign endFrame = rxValid && ((state == serial_command_error_checker_pkg::ST_BCC &&
                    pos == 4'h1) || (state == serial_command_error_checker_pkg::ST_SKIP &&
                    rxData == `CH_EOT));

  // ****************************************************************
  // per-byte detection and next state
  // ****************************************************************
  always_comb begin
    next_state = state;
    hit        = 1'b0;
    hitCode    = 16'h0000;
    if (rxValid) begin
      case (state)
        serial_command_error_checker_pkg::ST_IDLE: begin
          if (rxData == `CH_ENQ) begin
            next_state = serial_command_error_checker_pkg::ST_STN;
          end else begin
            next_state = serial_command_error_checker_pkg::ST_SKIP;
            hit        = 1'b1;
            hitCode    = `ERR_SYNTAX;
          end
        end
        serial_command_error_checker_pkg::ST_STN: begin
          if (!cc.isHex) begin
            hit     = 1'b1;
            hitCode = `ERR_DATA;
          end
          if (pos == 4'h1) begin
            next_state = serial_command_error_checker_pkg::ST_CMD;
          end
        end
        serial_command_error_checker_pkg::ST_CMD: begin
          next_state = serial_command_error_checker_pkg::ST_TYPE;
          if (!cc.isCmd) begin
            hit     = 1'b1;
            hitCode = `ERR_CMD;
          end
        end
        serial_command_error_checker_pkg::ST_TYPE: begin
          if ((pos == 4'h0 && rxData != `CH_S) ||
              (pos == 4'h1 && rxData != `CH_S && rxData != `CH_B)) begin
            hit     = 1'b1;
            hitCode = `ERR_CTYPE;
          end
          if (pos == 4'h1) begin
            next_state = serial_command_error_checker_pkg::ST_BODY;
          end
        end
        serial_command_error_checker_pkg::ST_BODY: begin
          if (rxData == `CH_EOT) begin
            next_state = serial_command_error_checker_pkg::ST_BCC;
            if (isMon && cnt > `MAX_MONREG) begin
              hit     = 1'b1;
              hitCode = (cmdLow == 8'h78) ? `ERR_MON_REG : `ERR_MON_EXE;
            end else if (isRw && addr >= `AREA_LIMIT) begin
              hit     = 1'b1;
              hitCode = `ERR_ADDR;
            end else if (isRw && isBlock && (cnt == 8'h00 ||
                         cnt > (byteType ? `MAX_BYTES : `MAX_WORDS))) begin
              hit     = 1'b1;
              hitCode = `ERR_SIZE;
            end
          end else if (rxData == `CH_ENQ) begin
            next_state = serial_command_error_checker_pkg::ST_SKIP;
            hit        = 1'b1;
            hitCode    = `ERR_SYNTAX;
          end else if (isRw && pos == `POS_PREFIX) begin
            if (rxData != `CH_PCT) begin
              hit     = 1'b1;
              hitCode = `ERR_PREFIX;
            end
          end else if (isRw && pos == `POS_AREA) begin
            if (!cc.isArea) begin
              hit     = 1'b1;
              hitCode = `ERR_AREA;
            end
          end else if (isRw && pos == `POS_DTYPE) begin
            if (!cc.isType) begin
              hit     = 1'b1;
              hitCode = `ERR_DTYPE;
            end
          end else if ((isRw && pos >= `POS_ADDR_LO &&
                        pos <= (isBlock ? `POS_CNT_HI : `POS_ADDR_HI)) ||
                       (isMon && pos <= 4'h1)) begin
            if (!cc.isHex) begin
              hit     = 1'b1;
              hitCode = `ERR_DATA;
            end
          end else if (!cc.isName) begin
            hit     = 1'b1;
            hitCode = `ERR_DATA;
          end
        end
        serial_command_error_checker_pkg::ST_BCC: begin
          if (!cc.isHex) begin
            hit     = 1'b1;
            hitCode = `ERR_BCC;
          end
          if (pos == 4'h1) begin
            next_state = serial_command_error_checker_pkg::ST_IDLE;
          end
        end
        serial_command_error_checker_pkg::ST_SKIP: begin
          if (rxData == `CH_EOT) begin
            next_state = serial_command_error_checker_pkg::ST_IDLE;
          end
        end
        default: begin
          next_state = serial_command_error_checker_pkg::ST_IDLE;
        end
      endcase
      if (state != serial_command_error_checker_pkg::ST_IDLE && byteCnt >= `MAX_FRAME) begin
        hit     = 1'b1;
        hitCode = `ERR_LENGTH;
      end
    end
    if ((rxOverrun || rxFrameErr) && state != serial_command_error_checker_pkg::ST_IDLE) begin
      hit     = 1'b1;
      hitCode = `ERR_LINE;
    end
  end

  // ****************************************************************
  // sequencing
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= serial_command_error_checker_pkg::ST_IDLE;
      pos   <= 4'h0;
    end else if (rxValid) begin
      state <= next_state;
      if (next_state != state) begin
        pos <= 4'h0;
      end else if (pos != 4'hf) begin
        pos <= pos + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      byteCnt <= 9'h000;
      bccSum  <= 8'h00;
    end else if (rxValid) begin
      if (state == serial_command_error_checker_pkg::ST_IDLE) begin
        byteCnt <= 9'h001;
        bccSum  <= rxData;
      end else begin
        if (byteCnt <= `MAX_FRAME) begin
          byteCnt <= byteCnt + 9'h001;
        end
        if (state != serial_command_error_checker_pkg::ST_BCC) begin
          bccSum <= bccSum + rxData;
        end
      end
    end
  end

  // ****************************************************************
  // field capture
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmdLow   <= 8'h00;
      isBlock  <= 1'b0;
      byteType <= 1'b0;
      addr     <= 16'h0000;
      cnt      <= 8'h00;
      bccHi    <= 4'h0;
    end else if (rxValid) begin
      case (state)
        serial_command_error_checker_pkg::ST_CMD: begin
          cmdLow <= rxData | `CASE_BIT;
          addr   <= 16'h0000;
          cnt    <= 8'h00;
        end
        serial_command_error_checker_pkg::ST_TYPE: begin
          if (pos == 4'h1) begin
            isBlock <= rxData == `CH_B;
          end
        end
        serial_command_error_checker_pkg::ST_BODY: begin
          if (isRw && pos == `POS_DTYPE) begin
            byteType <= cc.isByteType;
          end
          if (isRw && pos >= `POS_ADDR_LO && pos <= `POS_ADDR_HI) begin
            addr <= {addr[11:0], cc.hexVal};
          end
          if ((isRw && pos >= `POS_CNT_LO && pos <= `POS_CNT_HI) ||
              (isMon && pos <= 4'h1)) begin
            cnt <= {cnt[3:0], cc.hexVal};
          end
        end
        serial_command_error_checker_pkg::ST_BCC: begin
          bccHi <= cc.hexVal;
        end
        default: begin
          bccHi <= bccHi;
        end
      endcase
    end
  end

  // ****************************************************************
  // first error latch
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hasErr   <= 1'b0;
      firstErr <= 16'h0000;
    end else if (hit && (!hasErr || (rxValid &&
                 state == serial_command_error_checker_pkg::ST_IDLE))) begin
      hasErr   <= 1'b1;
      firstErr <= hitCode;
    end else if (endFrame || (rxValid && state == serial_command_error_checker_pkg::ST_IDLE)) begin
      hasErr   <= 1'b0;
      firstErr <= 16'h0000;
    end
  end

  // ****************************************************************
  // core link watch
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // link-ok level after reset, so reset alone never fakes a fault
      linkMeta  <= 1'b1;
      linkSync  <= 1'b1;
      linkPrev  <= 1'b1;
      coreFault <= 1'b0;
    end else begin
      linkMeta <= coreLinkOk;
      linkSync <= linkMeta;
      linkPrev <= linkSync;
      if (!linkSync && !linkPrev) begin
        coreFault <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // frame verdict
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      errValid <= 1'b0;
      frameOk  <= 1'b0;
      errCode  <= 16'h0000;
    end else begin
      errValid <= 1'b0;
      frameOk  <= 1'b0;
      if (endFrame) begin
        if (coreFault) begin
          errValid <= 1'b1;
          errCode  <= `ERR_CORE;
        end else if (hasErr || hit) begin
          errValid <= 1'b1;
          errCode  <= hasErr ? firstErr : hitCode;
        end else if ({bccHi, cc.hexVal} != bccSum) begin
          errValid <= 1'b1;
          errCode  <= `ERR_BCC;
        end else begin
          frameOk  <= 1'b1;
          errCode  <= 16'h0000;
        end
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_cmd_code: assert property (@(posedge ref_clk) disable iff (rst)
    rxValid && state == serial_command_error_checker_pkg::ST_CMD && !cc.isCmd && !hasErr
    && !rxOverrun && !rxFrameErr && byteCnt < `MAX_FRAME |=> firstErr == `ERR_CMD)
    else $error("bad command letter not latched");
  a_prefix_code: assert property (@(posedge ref_clk) disable iff (rst)
    hit && hitCode == `ERR_PREFIX && !hasErr |=> hasErr && firstErr == `ERR_PREFIX)
    else $error("missing prefix not latched");
  a_first_hold: assert property (@(posedge ref_clk) disable iff (rst)
    hasErr && !endFrame && !(rxValid && state == serial_command_error_checker_pkg::ST_IDLE)
    |=> $stable(firstErr))
    else $error("first error overwritten");
  a_core_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    coreFault |=> coreFault)
    else $error("core fault cleared");
  a_core_report: assert property (@(posedge ref_clk) disable iff (rst)
    endFrame && coreFault |=> errValid && errCode == `ERR_CORE)
    else $error("core fault not reported");
  a_end_verdict: assert property (@(posedge ref_clk) disable iff (rst)
    endFrame |=> (errValid ^ frameOk) ##1 !errValid && !frameOk)
    else $error("frame end without single verdict");
  a_length_code: assert property (@(posedge ref_clk) disable iff (rst)
    rxValid && state != serial_command_error_checker_pkg::ST_IDLE && byteCnt >= `MAX_FRAME
    && !rxOverrun && !rxFrameErr && !hasErr |=> firstErr == `ERR_LENGTH)
    else $error("oversize frame not flagged");
  a_line_code: assert property (@(posedge ref_clk) disable iff (rst)
    (rxOverrun || rxFrameErr) && state != serial_command_error_checker_pkg::ST_IDLE
    && !hasErr |=> firstErr == `ERR_LINE)
    else $error("line fault not flagged");
  a_enq_missing: assert property (@(posedge ref_clk) disable iff (rst)
    rxValid && state == serial_command_error_checker_pkg::ST_IDLE && rxData != `CH_ENQ
    |=> state == serial_command_error_checker_pkg::ST_SKIP && firstErr == `ERR_SYNTAX)
    else $error("missing start not flagged");
  a_ok_no_err: assert property (@(posedge ref_clk) disable iff (rst)
    frameOk |-> $past(bccSum) == {$past(bccHi), $past(cc.hexVal)} && !$past(hasErr))
    else $error("frame accepted with fault");
endmodule
`default_nettype wire

// [serial_command_error_checker_defs.svh]
// constants for the serial command error checker
// assumes ASCII bytes from a receiver already on ref_clk
`ifndef SERIAL_COMMAND_ERROR_CHECKER_DEFS_SVH
`define SERIAL_COMMAND_ERROR_CHECKER_DEFS_SVH

// ****************************************************************
// error codes
// ****************************************************************
`define ERR_CORE     16'h0001
`define ERR_DATA     16'h0011
`define ERR_CMD      16'h0021
`define ERR_CTYPE    16'h0031
`define ERR_AREA     16'h1132
`define ERR_SIZE     16'h1232
`define ERR_ADDR     16'h2232
`define ERR_DTYPE    16'h2432
`define ERR_PREFIX   16'h7132
`define ERR_MON_EXE  16'h0190
`define ERR_MON_REG  16'h0290
`define ERR_LINE     16'h6010
`define ERR_SYNTAX   16'h6030
`define ERR_LENGTH   16'h6040
`define ERR_BCC      16'h6050

// ****************************************************************
// characters
// ****************************************************************
`define CH_ENQ       8'h05
`define CH_EOT       8'h04
`define CH_PCT       8'h25
`define CH_S         8'h53
`define CH_B         8'h42
`define CASE_BIT     8'h20

// ****************************************************************
// limits and body positions
// ****************************************************************
`define MAX_FRAME    9'h100
`define MAX_BYTES    8'h80
`define MAX_WORDS    8'h40
`define MAX_MONREG   8'h09
`define AREA_LIMIT   16'h1000
`define POS_PREFIX   4'h0
`define POS_AREA     4'h1
`define POS_DTYPE    4'h2
`define POS_ADDR_LO  4'h3
`define POS_ADDR_HI  4'h6
`define POS_CNT_LO   4'h7
`define POS_CNT_HI   4'h8

`endif

// [serial_command_error_checker_pkg.sv]
// types for the serial command error checker
// assumes the defs header for all numbers
`default_nettype none
package serial_command_error_checker_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STN,
    ST_CMD,
    ST_TYPE,
    ST_BODY,
    ST_BCC,
    ST_SKIP
  } state_e;
  typedef logic [15:0] err_t;
endpackage
`default_nettype wire

// [char_class_if.sv]
// carrier between the frame checker and its character classifier
// assumes one received byte presented per cycle
`timescale 1ns/1ps
`default_nettype none
interface char_class_if;
  logic [7:0] ch;
  logic       isHex;
  logic [3:0] hexVal;
  logic       isName;
  logic       isCmd;
  logic       isArea;
  logic       isType;
  logic       isByteType;
  modport classifier (input ch, output isHex, hexVal, isName, isCmd, isArea, isType, isByteType);
  modport user (output ch, input isHex, hexVal, isName, isCmd, isArea, isType, isByteType);
endinterface
`default_nettype wire

// [ascii_char_class.sv]
// combinational ASCII classifier for command frame fields
// assumes the caller registers whatever it derives from these flags
`timescale 1ns/1ps
`default_nettype none
`include "serial_command_error_checker_defs.svh"
module ascii_char_class (
  char_class_if.classifier cc
);
  logic [7:0] low;

  // ****************************************************************
  // classification
  // ****************************************************************
  always_comb begin
    low       = cc.ch | `CASE_BIT;
    cc.isHex  = 1'b0;
    cc.hexVal = 4'h0;
    if (cc.ch >= 8'h30 && cc.ch <= 8'h39) begin
      cc.isHex  = 1'b1;
      cc.hexVal = cc.ch[3:0];
    end else if (cc.ch >= 8'h41 && cc.ch <= 8'h46) begin
      cc.isHex  = 1'b1;
      cc.hexVal = cc.ch[3:0] + 4'h9;
    end
    cc.isName = (cc.ch >= 8'h30 && cc.ch <= 8'h39) ||
                (low >= 8'h61 && low <= 8'h7a) ||
                cc.ch == `CH_PCT || cc.ch == 8'h5f || cc.ch == 8'h2e;
    cc.isCmd  = low == 8'h77 || low == 8'h72 || low == 8'h78 ||
                low == 8'h79 || low == 8'h73;
    cc.isArea = cc.ch == 8'h50 || cc.ch == 8'h4d || cc.ch == 8'h4c ||
                cc.ch == 8'h4b || cc.ch == 8'h54 || cc.ch == 8'h43 ||
                cc.ch == 8'h46 || cc.ch == 8'h44 || cc.ch == 8'h53;
    cc.isByteType = low == 8'h78;
    cc.isType = low == 8'h78 || low == 8'h77;
  end
endmodule
`default_nettype wire

// [serial_host_model.sv]
// host station model: builds command frames and sends them byte by byte
// assumes bytes are taken on the rising edge of ref_clk; drives at falling edge
`timescale 1ns/1ps
`default_nettype none
`include "serial_command_error_checker_defs.svh"
module serial_host_model (
  input  wire logic       ref_clk,
  output var  logic       rxValid,
  output var  logic [7:0] rxData,
  output var  logic       rxOverrun,
  output var  logic       rxFrameErr
);
  logic [7:0] frameQ[$];

  initial begin
    rxValid    = 1'b0;
    rxData     = 8'h00;
    rxOverrun  = 1'b0;
    rxFrameErr = 1'b0;
  end

  function automatic logic [7:0] hex_char(input logic [3:0] v);
    return (v < 4'ha) ? {4'h3, v} : (8'h37 + {4'h0, v});
  endfunction

  // one byte per cycle, same character settings as the device
  task automatic put_byte(input logic [7:0] b, input logic ovr, input logic fer);
    @(negedge ref_clk);
    rxValid    = 1'b1;
    rxData     = b;
    rxOverrun  = ovr;
    rxFrameErr = fer;
  endtask

  // released data line shows the inverse of the last byte
  task automatic release_line();
    @(negedge ref_clk);
    rxValid    = 1'b0;
    rxData     = ~rxData;
    rxOverrun  = 1'b0;
    rxFrameErr = 1'b0;
  endtask

  // mode bits: 0 bad check, 1 no start, 2 no check chars, 3 overrun, 4 framing, 5 oversize
  task automatic send_frame(input string body, input int mode);
    logic [7:0] sum;
    frameQ.delete();
    if (!mode[1]) frameQ.push_back(`CH_ENQ);
    frameQ.push_back(8'h30);
    frameQ.push_back(8'h31);
    for (int i = 0; i < body.len(); i++) frameQ.push_back(body[i]);
    if (mode[5]) for (int i = 0; i < 260; i++) frameQ.push_back(8'h61);
    frameQ.push_back(`CH_EOT);
    sum = 8'h00;
    foreach (frameQ[i]) sum = sum + frameQ[i];
    if (mode[0]) sum = sum + 8'h01;
    if (!mode[2]) begin
      frameQ.push_back(hex_char(sum[7:4]));
      frameQ.push_back(hex_char(sum[3:0]));
    end
    foreach (frameQ[i]) put_byte(frameQ[i], mode[3] && i == 4, mode[4] && i == 4);
    release_line();
  endtask

  task automatic idle_fault();
    @(negedge ref_clk);
    rxOverrun  = 1'b1;
    rxFrameErr = 1'b1;
    @(negedge ref_clk);
    rxOverrun  = 1'b0;
    rxFrameErr = 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the serial command error checker
// assumes the host model drives bytes; bench drives reset and core link
`timescale 1ns/1ps
`default_nettype none
`include "serial_command_error_checker_defs.svh"
module tb_top;
  logic        ref_clk;
  logic        rst;
  logic        coreLinkOk;
  logic        rxValid;
  logic [7:0]  rxData;
  logic        rxOverrun;
  logic        rxFrameErr;
  logic        errValid;
  logic [15:0] errCode;
  logic        frameOk;
  logic        coreFault;
  logic [15:0] gotCode;
  logic        gotOk;
  logic        gotErr;
  int          verdictCnt;
  int          n_fail;
  int          tests_run;

  serial_command_error_checker uut (
    .ref_clk(ref_clk), .rst(rst), .rxValid(rxValid), .rxData(rxData),
    .rxOverrun(rxOverrun), .rxFrameErr(rxFrameErr), .coreLinkOk(coreLinkOk),
    .errValid(errValid), .errCode(errCode), .frameOk(frameOk), .coreFault(coreFault)
  );
  serial_host_model host (
    .ref_clk(ref_clk), .rxValid(rxValid), .rxData(rxData),
    .rxOverrun(rxOverrun), .rxFrameErr(rxFrameErr)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (errValid === 1'b1 || frameOk === 1'b1) begin
      gotCode    <= errCode;
      gotOk      <= frameOk;
      gotErr     <= errValid;
      verdictCnt <= verdictCnt + 1;
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic run_case(input string nm, input string body, input int mode,
                          input serial_command_error_checker_pkg::err_t exp);
    int c0;
    int k;
    c0 = verdictCnt;
    host.send_frame(body, mode);
    k = 0;
    while (verdictCnt == c0 && k < 40) begin
      @(negedge ref_clk);
      k++;
    end
    if (verdictCnt == c0) begin
      n_fail++;
      $display("BAD %s expected verdict seen none", nm);
      end_sim();
    end
    repeat (3) @(negedge ref_clk);
    check(nm, gotCode, exp);
    check({nm, "_ok"}, {15'h0000, gotOk}, {15'h0000, exp == 16'h0000});
    check({nm, "_err"}, {15'h0000, gotErr}, {15'h0000, exp != 16'h0000});
    check({nm, "_once"}, 16'(verdictCnt - c0), 16'h0001);
  endtask

  task automatic apply_reset();
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic sc_commands();
    string goodQ[10] = '{"wSS%MW0010", "WSS%MW0010", "rSS%MW0010", "RSS%MW0010", "xSS09",
                         "XSS00", "ySS09", "YSS01", "sSSab", "SSSa_%.Z9"};
    foreach (goodQ[i]) run_case("cmd_ok", goodQ[i], 0, 16'h0000);
    run_case("cmd_bad", "qSS%MW0010", 0, `ERR_CMD);
    run_case("ctype_bad", "rSX%MW0010", 0, `ERR_CTYPE);
    run_case("ctype_sb", "rSB%MW001001", 0, 16'h0000);
    run_case("first_wins", "qSX%QB0010", 0, `ERR_CMD);
    run_case("name_bad", "sSSa#b", 0, `ERR_DATA);
  endtask

  task automatic sc_fields();
    string areas = "PMLKTCFDS";
    for (int i = 0; i < 9; i++)
      run_case("area_ok", {"rSS%", areas.substr(i, i), "W0010"}, 0, 16'h0000);
    run_case("area_bad", "rSS%QW0010", 0, `ERR_AREA);
    run_case("dtype_x", "rSS%Mx0010", 0, 16'h0000);
    run_case("dtype_b", "rSS%MB0010", 0, `ERR_DTYPE);
    run_case("dtype_d", "rSS%Md0010", 0, `ERR_DTYPE);
    run_case("prefix", "rSSMW0010", 0, `ERR_PREFIX);
  endtask

  task automatic sc_limits();
    run_case("cnt_min", "rSB%MX001001", 0, 16'h0000);
    run_case("cnt_max", "rSB%MX001080", 0, 16'h0000);
    run_case("cnt_over", "rSB%MX001081", 0, `ERR_SIZE);
    run_case("cnt_zero", "rSB%MX001000", 0, `ERR_SIZE);
    run_case("cnt_w_max", "rSB%MW001040", 0, 16'h0000);
    run_case("cnt_w_over", "rSB%MW001041", 0, `ERR_SIZE);
    run_case("addr_top", "rSS%MW0FFF", 0, 16'h0000);
    run_case("addr_over", "rSS%DW1000", 0, `ERR_ADDR);
    run_case("mon_reg", "xSS0A", 0, `ERR_MON_REG);
    run_case("mon_exe", "ySS0A", 0, `ERR_MON_EXE);
  endtask

  task automatic sc_framing();
    run_case("bcc_bad", "rSS%MW0010", 1, `ERR_BCC);
    run_case("no_start", "rSS%MW0010", 6, `ERR_SYNTAX);
    run_case("enq_body", "rSS%\005W0010", 4, `ERR_SYNTAX);
    run_case("overrun", "rSS%MW0010", 8, `ERR_LINE);
    run_case("framing", "rSS%MW0010", 16, `ERR_LINE);
    host.idle_fault();
    run_case("idle_fault", "rSS%MW0010", 0, 16'h0000);
    run_case("oversize", "sSS", 32, `ERR_LENGTH);
    apply_reset();
  endtask

  task automatic sc_core();
    coreLinkOk = 1'b0;
    repeat (6) @(negedge ref_clk);
    check("core_fault", {15'h0000, coreFault}, 16'h0001);
    run_case("core_code", "rSS%MW0010", 0, `ERR_CORE);
    coreLinkOk = 1'b1;
    repeat (6) @(negedge ref_clk);
    check("core_sticky", {15'h0000, coreFault}, 16'h0001);
    apply_reset();
    check("core_clear", {15'h0000, coreFault}, 16'h0000);
    check("code_clear", errCode, 16'h0000);
  endtask

  initial begin
    rst        = 1'b1;
    coreLinkOk = 1'b1;
    repeat (8) @(negedge ref_clk);
    check("rst_code", errCode, 16'h0000);
    check("rst_flags", {13'h0000, errValid, frameOk, coreFault}, 16'h0000);
    rst = 1'b0;
    @(negedge ref_clk);
    sc_commands();
    sc_fields();
    sc_limits();
    sc_framing();
    sc_core();
    end_sim();
  end
endmodule
`default_nettype wire
